// file: rtl/trlc_pkg.sv
// Package of constants for the temperature readout and limit check block
package trlc_pkg;

  // ****************************************************************
  // Code format
  // ****************************************************************
  localparam int          CODE_W      = 12;
  localparam int          FRAC_BITS   = 3;
  localparam logic [11:0] CODE_MINUS  = 12'h400;
  localparam logic [11:0] CODE_ZERO   = 12'h800;
  localparam logic [11:0] CODE_PLUS   = 12'hc00;
  localparam logic [11:0] CODE_RESET  = 12'h800;

  // ****************************************************************
  // Averaging
  // ****************************************************************
  localparam int          AVG_LOG2    = 4;
  localparam int          AVG_COUNT   = 16;
  localparam int          ACC_W       = 16;
  localparam logic [3:0]  AVG_LAST    = 4'hf;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_MHZ     = 100;
  localparam int          MEAS_MS     = 600;
  localparam int          MEAS_CYC    = MEAS_MS * 1000 * CLK_MHZ;
  localparam int          CYCLE_CYC   = MEAS_CYC / AVG_COUNT;
  localparam int          PHASE_CYC   = CYCLE_CYC / 2;

  // ****************************************************************
  // Channels
  // ****************************************************************
  localparam int          CH_REMOTE   = 0;
  localparam int          CH_LOCAL    = 1;
  localparam int          NUM_CH      = 2;

  typedef enum logic [1:0] {
    TRLC_IDLE = 2'b00,
    TRLC_LOW  = 2'b01,
    TRLC_HIGH = 2'b10,
    TRLC_DONE = 2'b11
  } trlc_state_t;

endpackage : trlc_pkg

// file: rtl/trlc_limit_cmp.sv
// Limit comparator for one temperature channel
`timescale 1ns/1ps
module trlc_limit_cmp (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        valid_in,
  input  wire logic [11:0] result_in,
  input  wire logic [11:0] limit_in,
  input  wire logic        limit_is_lower_in,
  output logic             warn_out
);

  // ****************************************************************
  // Compare
  // ****************************************************************
  wire logic over_w  = result_in > limit_in;
  wire logic under_w = result_in < limit_in;
  wire logic hit_w   = limit_is_lower_in ? under_w : over_w;

  logic warn_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) warn_q <= 1'b0;
    else if (valid_in) warn_q <= hit_w;
  end
  assign warn_out = warn_q;

  a_warn_follows: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    valid_in |=> warn_out == $past(hit_w))
    else $error("Warning does not match compare");

endmodule : trlc_limit_cmp

// file: rtl/trlc_top.sv
// Temperature readout, averaging and limit check
`timescale 1ns/1ps
module trlc_top #(
  parameter int MEAS_CYC = trlc_pkg::MEAS_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        enable_in,
  output logic             bias_high_out,
  output logic             adc_start_out,
  input  wire logic        adc_done_in,
  input  wire logic [11:0] adc_code_in,
  input  wire logic        local_valid_in,
  input  wire logic [11:0] local_code_in,
  input  wire logic [11:0] remote_limit_in,
  input  wire logic        remote_lower_in,
  input  wire logic [11:0] local_limit_in,
  input  wire logic        local_lower_in,
  output logic [11:0]      remote_temp_out,
  output logic [11:0]      local_temp_out,
  output logic             remote_valid_out,
  output logic             seq_warn_remote_out,
  output logic             seq_warn_local_out,
  output logic [1:0]       warn_status_out
);

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam int        CYCLE_CYC = MEAS_CYC / trlc_pkg::AVG_COUNT;
  localparam int        PH_CYC    = (CYCLE_CYC / 2 < 1) ? 1 : CYCLE_CYC / 2;
  localparam logic [31:0] PH_LAST = 32'(PH_CYC - 1);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [11:0] avg16(input logic [15:0] acc);
    avg16 = acc[15:4];
  endfunction : avg16

  // ****************************************************************
  // Synchronised inputs (from the analog front end domain)
  // ****************************************************************
  logic [1:0]  done_sync_q;
  logic [1:0]  en_sync_q;
  logic [1:0]  lv_sync_q;
  logic [11:0] code_s1_q;
  logic [11:0] code_s2_q;
  logic [11:0] lcode_s1_q;
  logic [11:0] lcode_s2_q;
  // Codes are held stable by their sources until after the capture edge
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_sync_q <= 2'b00;
      en_sync_q   <= 2'b00;
      lv_sync_q   <= 2'b00;
      code_s1_q   <= 12'h000;
      code_s2_q   <= 12'h000;
      lcode_s1_q  <= 12'h000;
      lcode_s2_q  <= 12'h000;
    end else begin
      done_sync_q <= {done_sync_q[0], adc_done_in};
      en_sync_q   <= {en_sync_q[0], enable_in};
      lv_sync_q   <= {lv_sync_q[0], local_valid_in};
      code_s1_q   <= adc_code_in;
      code_s2_q   <= code_s1_q;
      lcode_s1_q  <= local_code_in;
      lcode_s2_q  <= lcode_s1_q;
    end
  end
  logic done_prev_q;
  logic lv_prev_q;
  wire logic done_rise_w = done_sync_q[1] & ~done_prev_q;
  wire logic lv_rise_w   = lv_sync_q[1] & ~lv_prev_q;

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  trlc_pkg::trlc_state_t state_q, state_d;
  logic [31:0] ph_cnt_q;
  logic [3:0]  cyc_cnt_q;
  logic [15:0] acc_q;
  logic [11:0] lo_code_q;
  logic [11:0] remote_q;
  logic [11:0] local_q;
  logic        rvalid_q;
  logic        start_q;

  wire logic ph_end_w  = ph_cnt_q == PH_LAST;
  wire logic last_cyc_w = cyc_cnt_q == trlc_pkg::AVG_LAST;
  // Signed difference of the two bias phases (high minus low), re-centred on zero degrees
  wire logic [11:0] diff_w = code_s2_q - lo_code_q + trlc_pkg::CODE_ZERO;
  wire logic [15:0] acc_add_w = acc_q + {4'h0, diff_w};

  always_comb begin
    state_d = state_q;
    case (state_q)
      trlc_pkg::TRLC_IDLE: if (en_sync_q[1]) state_d = trlc_pkg::TRLC_LOW;
      trlc_pkg::TRLC_LOW:  if (ph_end_w) state_d = trlc_pkg::TRLC_HIGH;
      trlc_pkg::TRLC_HIGH: if (ph_end_w) begin
        state_d = last_cyc_w ? trlc_pkg::TRLC_DONE : trlc_pkg::TRLC_LOW;
      end
      trlc_pkg::TRLC_DONE: state_d = trlc_pkg::TRLC_IDLE;
      default:             state_d = trlc_pkg::TRLC_IDLE;
    endcase
  end

  wire logic in_meas_w = state_q == trlc_pkg::TRLC_LOW ||
                         state_q == trlc_pkg::TRLC_HIGH;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q     <= trlc_pkg::TRLC_IDLE;
      ph_cnt_q    <= 32'h0;
      done_prev_q <= 1'b0;
      lv_prev_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      ph_cnt_q    <= (!in_meas_w || ph_end_w) ? 32'h0 : ph_cnt_q + 32'h1;
      done_prev_q <= done_sync_q[1];
      lv_prev_q   <= lv_sync_q[1];
    end
  end

  // Bias alternates I / N x I within every cycle
  assign bias_high_out = state_q == trlc_pkg::TRLC_HIGH;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) start_q <= 1'b0;
    // Start early so the answer lands inside the phase that it measures
    else start_q <= in_meas_w && ph_cnt_q == 32'h0;
  end
  assign adc_start_out = start_q;

  // Cycle count and accumulation
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc_cnt_q <= 4'h0;
      lo_code_q <= trlc_pkg::CODE_RESET;
      acc_q     <= 16'h0;
    end else if (state_q == trlc_pkg::TRLC_IDLE) begin
      cyc_cnt_q <= 4'h0;
      acc_q     <= 16'h0;
    end else begin
      if (done_rise_w && state_q == trlc_pkg::TRLC_LOW)
        lo_code_q <= code_s2_q;
      if (done_rise_w && state_q == trlc_pkg::TRLC_HIGH)
        acc_q <= acc_add_w;
      if (state_q == trlc_pkg::TRLC_HIGH && ph_end_w)
        cyc_cnt_q <= cyc_cnt_q + 4'h1;
    end
  end

  // ****************************************************************
  // Result store
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remote_q <= trlc_pkg::CODE_RESET;
      local_q  <= trlc_pkg::CODE_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= state_q == trlc_pkg::TRLC_DONE;
      if (state_q == trlc_pkg::TRLC_DONE)
        remote_q <= avg16(acc_q);
      if (lv_rise_w)
        local_q <= lcode_s2_q;
    end
  end
  assign remote_temp_out  = remote_q;
  assign local_temp_out   = local_q;
  assign remote_valid_out = rvalid_q;

  // ****************************************************************
  // Limit checks
  // ****************************************************************
  trlc_limit_cmp u_cmp_remote (
    .ref_clk_in        (ref_clk_in),
    .rst_n_in          (rst_n_in),
    .valid_in          (rvalid_q),
    .result_in         (remote_q),
    .limit_in          (remote_limit_in),
    .limit_is_lower_in (remote_lower_in),
    .warn_out          (seq_warn_remote_out)
  );
  trlc_limit_cmp u_cmp_local (
    .ref_clk_in        (ref_clk_in),
    .rst_n_in          (rst_n_in),
    .valid_in          (lv_prev_q),
    .result_in         (local_q),
    .limit_in          (local_limit_in),
    .limit_is_lower_in (local_lower_in),
    .warn_out          (seq_warn_local_out)
  );
  assign warn_status_out = {seq_warn_local_out, seq_warn_remote_out};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_bias_phase: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == trlc_pkg::TRLC_LOW && ph_end_w |=> bias_high_out)
    else $error("Bias did not switch high");
  a_avg_store: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == trlc_pkg::TRLC_DONE |=> remote_q == $past(acc_q) >> 4)
    else $error("Stored result is not sum over sixteen");
  a_sixteen_cyc: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == trlc_pkg::TRLC_DONE |-> $past(cyc_cnt_q) == 4'hf)
    else $error("Result stored before sixteen cycles");
  a_valid_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    remote_valid_out |=> !remote_valid_out)
    else $error("Valid longer than one cycle");
  a_status_map: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    warn_status_out[0] == seq_warn_remote_out)
    else $error("Status bit differs from warning");
  a_idle_bias: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    state_q == trlc_pkg::TRLC_IDLE |-> !bias_high_out)
    else $error("Bias high while idle");
  a_remote_warn: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rvalid_q && !remote_lower_in && remote_q > remote_limit_in
    |=> seq_warn_remote_out)
    else $error("Over limit without warning");
  a_local_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !lv_rise_w |=> $stable(local_q))
    else $error("Local result changed without sample");

  c_result: cover property (@(posedge ref_clk_in) remote_valid_out);
  c_warn: cover property (@(posedge ref_clk_in) seq_warn_remote_out);
  c_local: cover property (@(posedge ref_clk_in) seq_warn_local_out);

endmodule : trlc_top

// file: sim/trlc_sensor_model.sv
// Behavioural remote diode and converter front end
`timescale 1ns/1ps
module trlc_sensor_model (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        bias_high_in,
  input  wire logic        adc_start_in,
  input  wire logic [3:0]  delay_in,
  input  wire logic [11:0] base_in,
  input  wire logic [11:0] diff_in,
  output logic             adc_done_out,
  output logic [11:0]      adc_code_out
);
  logic [4:0] wait_q;
  logic [2:0] hold_q;
  logic       bias_q;
  // ****************************************************************
  // Conversion answer
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q       <= 5'h00;
      hold_q       <= 3'h0;
      bias_q       <= 1'b0;
      adc_done_out <= 1'b0;
      adc_code_out <= 12'h000;
    end else if (adc_start_in) begin
      wait_q <= {1'b0, delay_in} + 5'h01;
      bias_q <= bias_high_in;
    end else if (wait_q == 5'h01) begin
      wait_q       <= 5'h00;
      hold_q       <= 3'h3;
      adc_done_out <= 1'b1;
      adc_code_out <= bias_q ? base_in + diff_in : base_in;
    end else begin
      if (wait_q != 5'h00) wait_q <= wait_q - 5'h01;
      if (hold_q == 3'h1) begin
        adc_done_out <= 1'b0;
        adc_code_out <= ~adc_code_out;
      end
      if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    end
  end
endmodule : trlc_sensor_model

// file: sim/tb_temperature_readout_limit_check.sv
// Self-checking bench for the temperature readout block
`timescale 1ns/1ps
module tb_temperature_readout_limit_check;
  logic ref_clk_in, rst_n_in, enable_in, adc_done_in, local_valid_in;
  logic remote_lower_in, local_lower_in, bias_high_out, adc_start_out;
  logic remote_valid_out, seq_warn_remote_out, seq_warn_local_out;
  logic [11:0] adc_code_in, local_code_in, remote_limit_in, local_limit_in;
  logic [11:0] remote_temp_out, local_temp_out, base_code, diff_code;
  logic [1:0]  warn_status_out;
  logic [3:0]  delay;
  int          err_total, num_checks;
  trlc_top #(.MEAS_CYC(320)) DUT (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .enable_in(enable_in),
    .bias_high_out(bias_high_out), .adc_start_out(adc_start_out),
    .adc_done_in(adc_done_in), .adc_code_in(adc_code_in),
    .local_valid_in(local_valid_in), .local_code_in(local_code_in),
    .remote_limit_in(remote_limit_in), .remote_lower_in(remote_lower_in),
    .local_limit_in(local_limit_in), .local_lower_in(local_lower_in),
    .remote_temp_out(remote_temp_out), .local_temp_out(local_temp_out),
    .remote_valid_out(remote_valid_out),
    .seq_warn_remote_out(seq_warn_remote_out),
    .seq_warn_local_out(seq_warn_local_out),
    .warn_status_out(warn_status_out));
  trlc_sensor_model u_model (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .bias_high_in(bias_high_out), .adc_start_in(adc_start_out),
    .delay_in(delay), .base_in(base_code), .diff_in(diff_code),
    .adc_done_out(adc_done_in), .adc_code_out(adc_code_in));
  // ****************************************************************
  // Clock and helpers
  // ****************************************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_state();
    chk(remote_temp_out === 12'h800 && local_temp_out === 12'h800,
        "temp reset");
    chk(warn_status_out === 2'h0 && remote_valid_out === 1'b0,
        "flag reset");
  endtask : reset_state
  task automatic remote_meas(input logic [3:0] dly, input logic [11:0] base,
    input logic [11:0] diff, input logic [11:0] lim, input logic low,
    input logic [11:0] exp_code, input logic exp_w);
    int cyc;
    int rises;
    logic last_b;
    cyc = 0;
    rises = 0;
    last_b = 1'b0;
    @(posedge ref_clk_in);
    delay <= dly;
    base_code <= base;
    diff_code <= diff;
    remote_limit_in <= lim;
    remote_lower_in <= low;
    enable_in <= 1'b1;
    while (remote_valid_out !== 1'b1 && cyc < 2000) begin
      @(posedge ref_clk_in);
      // Enable is only looked at in idle: drop it once a run is under way
      if (rises > 0) enable_in <= 1'b0;
      #1;
      cyc++;
      if (bias_high_out === 1'b1 && last_b !== 1'b1) rises++;
      last_b = bias_high_out;
    end
    chk(remote_temp_out === exp_code, "remote code");
    chk(rises == 16, "bias switch count");
    chk(cyc >= 320 && cyc <= 360, "measurement time");
    @(posedge ref_clk_in);
    enable_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk(seq_warn_remote_out === exp_w, "remote warning");
    chk(warn_status_out[0] === exp_w, "remote status");
    repeat (60) @(posedge ref_clk_in);
  endtask : remote_meas
  task automatic local_meas(input logic [11:0] code, input logic [11:0] lim,
    input logic low, input logic exp_w);
    @(posedge ref_clk_in);
    local_code_in <= code;
    local_limit_in <= lim;
    local_lower_in <= low;
    local_valid_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    local_valid_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    #1;
    chk(local_temp_out === code, "local code");
    chk(seq_warn_local_out === exp_w, "local warning");
    chk(warn_status_out[1] === exp_w, "local status");
  endtask : local_meas
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    err_total = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    {enable_in, local_valid_in, remote_lower_in, local_lower_in} = 4'h0;
    {local_code_in, remote_limit_in, local_limit_in} = {3{12'h800}};
    {delay, base_code, diff_code} = {4'h0, 12'h100, 12'h000};
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1;
    reset_state();
    remote_meas(4'h0, 12'h100, 12'h0cc, 12'h8cb, 1'b0, 12'h8cc,
                1'b1);
    remote_meas(4'h3, 12'h300, 12'hf38, 12'h738, 1'b0, 12'h738,
                1'b0);
    remote_meas(4'h2, 12'h300, 12'hf38, 12'h739, 1'b1, 12'h738,
                1'b1);
    local_meas(12'h738, 12'h800, 1'b1, 1'b1);
    local_meas(12'h8cc, 12'h8cc, 1'b0, 1'b0);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_temperature_readout_limit_check
